// ---- rtl/port_phy_tuning_regs.sv ----
// Port drive-boost and data-pin swap registers with their per-port controls
//
// Overview of operation
// - Downstream port 4 boost selector comes from boost register bits 7:6.
// - Downstream port 3 boost selector comes from boost register bits 5:4.
// - Downstream port 2 boost selector comes from boost register bits 3:2.
// - Downstream port 1 boost selector comes from boost register bits 1:0.
// - Selector 00 none, 01 low, 10 medium, 11 high boost.
// - Swap bit 0 keeps pins straight; 1 exchanges positive and negative pins.
// - Swap register bit 0 swaps the upstream port data pins.
// - Swap register bits 1 to 4 swap downstream ports 1 to 4.
// - Swap bits 7 to 5 are reserved, have no function, read zero.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module port_phy_tuning_regs
   import port_phy_pkg::*;
(
   input  wire logic                                 clock_i,
   input  wire logic                                 reset_i,
   // Register port
   input  wire logic [port_phy_pkg::ADDR_W-1:0]      reg_addr_i,
   input  wire logic [port_phy_pkg::DATA_W-1:0]      reg_wdata_i,
   input  wire logic                                 reg_write_i,
   input  wire logic                                 reg_read_i,
   output logic      [port_phy_pkg::DATA_W-1:0]      reg_rdata_o,
   // Raw boost selectors toward the downstream transceivers
   output logic      [port_phy_pkg::BOOST_W-1:0]     ds1_drive_boost_o,
   output logic      [port_phy_pkg::BOOST_W-1:0]     ds2_drive_boost_o,
   output logic      [port_phy_pkg::BOOST_W-1:0]     ds3_drive_boost_o,
   output logic      [port_phy_pkg::BOOST_W-1:0]     ds4_drive_boost_o,
   // One-hot drive levels toward the downstream transceivers
   output logic      [port_phy_pkg::LEVEL_W-1:0]     ds1_drive_level_o,
   output logic      [port_phy_pkg::LEVEL_W-1:0]     ds2_drive_level_o,
   output logic      [port_phy_pkg::LEVEL_W-1:0]     ds3_drive_level_o,
   output logic      [port_phy_pkg::LEVEL_W-1:0]     ds4_drive_level_o,
   output logic      [port_phy_pkg::DS_COUNT-1:0]    ds_boost_active_o,
   // Swap control, index 0 upstream, 1 to 4 downstream ports
   output logic      [port_phy_pkg::PORT_COUNT-1:0]  pin_swap_bits_o,
   // Core side of each port lane
   input  wire logic [port_phy_pkg::PORT_COUNT-1:0]  core_pos_out_i,
   input  wire logic [port_phy_pkg::PORT_COUNT-1:0]  core_pos_oe_n_i,
   input  wire logic [port_phy_pkg::PORT_COUNT-1:0]  core_neg_out_i,
   input  wire logic [port_phy_pkg::PORT_COUNT-1:0]  core_neg_oe_n_i,
   output logic      [port_phy_pkg::PORT_COUNT-1:0]  core_pos_in_o,
   output logic      [port_phy_pkg::PORT_COUNT-1:0]  core_neg_in_o,
   // Pin side of each port lane
   input  wire logic [port_phy_pkg::PORT_COUNT-1:0]  positive_data_pin_i,
   output logic      [port_phy_pkg::PORT_COUNT-1:0]  positive_data_pin_o,
   output logic      [port_phy_pkg::PORT_COUNT-1:0]  positive_data_pin_oe_n_o,
   input  wire logic [port_phy_pkg::PORT_COUNT-1:0]  negative_data_pin_i,
   output logic      [port_phy_pkg::PORT_COUNT-1:0]  negative_data_pin_o,
   output logic      [port_phy_pkg::PORT_COUNT-1:0]  negative_data_pin_oe_n_o
);

   import port_phy_pkg::*;

   logic [DATA_W-1:0]     boost_reg;
   logic [DATA_W-1:0]     boost_next;
   logic [PORT_COUNT-1:0] swap_reg;
   logic [PORT_COUNT-1:0] swap_next;
   logic [DATA_W-1:0]     rdata_reg;
   logic [DATA_W-1:0]     rdata_next;
   logic                  boost_hit;
   logic                  swap_hit;

   assign boost_hit = (reg_addr_i == BOOST_OFFSET);
   assign swap_hit  = (reg_addr_i == SWAP_OFFSET);

   always_comb begin
      boost_next = boost_reg;
      if (reg_write_i && boost_hit) begin
         boost_next = reg_wdata_i;
      end
   end

   always_comb begin
      swap_next = swap_reg;
      if (reg_write_i && swap_hit) begin
         swap_next = reg_wdata_i[PORT_COUNT-1:0];
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         boost_reg <= BOOST_RESET;
      end else begin
         boost_reg <= boost_next;
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         swap_reg <= SWAP_RESET;
      end else begin
         swap_reg <= swap_next;
      end
   end

   // Unmapped addresses read as zero; the reserved swap bits read as zero
   always_comb begin
      rdata_next = READ_IDLE;
      if (reg_read_i) begin
         if (boost_hit) begin
            rdata_next = boost_reg;
         end else if (swap_hit) begin
            rdata_next = {SWAP_RSVD_READ, swap_reg};
         end
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_reg <= READ_IDLE;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata_o = rdata_reg;

   assign ds4_drive_boost_o = boost_field(boost_reg, DS4_BOOST_LSB);
   assign ds3_drive_boost_o = boost_field(boost_reg, DS3_BOOST_LSB);
   assign ds2_drive_boost_o = boost_field(boost_reg, DS2_BOOST_LSB);
   assign ds1_drive_boost_o = boost_field(boost_reg, DS1_BOOST_LSB);

   // Levels load from the next value so they change on the same edge as the register
   // selector decode
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         ds1_drive_level_o <= LEVEL_NONE;
         ds2_drive_level_o <= LEVEL_NONE;
         ds3_drive_level_o <= LEVEL_NONE;
         ds4_drive_level_o <= LEVEL_NONE;
      end else begin
         ds1_drive_level_o <= boost_onehot(boost_field(boost_next, DS1_BOOST_LSB));
         ds2_drive_level_o <= boost_onehot(boost_field(boost_next, DS2_BOOST_LSB));
         ds3_drive_level_o <= boost_onehot(boost_field(boost_next, DS3_BOOST_LSB));
         ds4_drive_level_o <= boost_onehot(boost_field(boost_next, DS4_BOOST_LSB));
      end
   end

   // Flags ports running above nominal drive, a hint for compliance checks
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         ds_boost_active_o <= '0;
      end else begin
         ds_boost_active_o[0] <= (boost_field(boost_next, DS1_BOOST_LSB) != BOOST_NONE);
         ds_boost_active_o[1] <= (boost_field(boost_next, DS2_BOOST_LSB) != BOOST_NONE);
         ds_boost_active_o[2] <= (boost_field(boost_next, DS3_BOOST_LSB) != BOOST_NONE);
         ds_boost_active_o[3] <= (boost_field(boost_next, DS4_BOOST_LSB) != BOOST_NONE);
      end
   end

   assign pin_swap_bits_o = swap_reg;

   // Changing a swap bit during traffic corrupts the packet in flight;
   // software is expected to set it before the port is enabled.
   for (genvar p = 0; p < PORT_COUNT; p++) begin : g_lane
      pin_swap_lane u_lane (
         .clock_i                  (clock_i),
         .reset_i                  (reset_i),
         .swap_i                   (swap_reg[p]),
         .core_pos_out_i           (core_pos_out_i[p]),
         .core_pos_oe_n_i          (core_pos_oe_n_i[p]),
         .core_neg_out_i           (core_neg_out_i[p]),
         .core_neg_oe_n_i          (core_neg_oe_n_i[p]),
         .core_pos_in_o            (core_pos_in_o[p]),
         .core_neg_in_o            (core_neg_in_o[p]),
         .positive_data_pin_i      (positive_data_pin_i[p]),
         .positive_data_pin_o      (positive_data_pin_o[p]),
         .positive_data_pin_oe_n_o (positive_data_pin_oe_n_o[p]),
         .negative_data_pin_i      (negative_data_pin_i[p]),
         .negative_data_pin_o      (negative_data_pin_o[p]),
         .negative_data_pin_oe_n_o (negative_data_pin_oe_n_o[p])
      );
   end

endmodule

// ---- inc/port_phy_pkg.sv ----
// Constants, field layout and decode helpers for the port tuning registers
package port_phy_pkg;

   localparam int ADDR_W       = 8;
   localparam int DATA_W       = 8;
   localparam int BOOST_W      = 2;
   localparam int LEVEL_W      = 4;
   localparam int DS_COUNT     = 4;
   localparam int PORT_COUNT   = 5;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] BOOST_OFFSET = 8'hf8;
   localparam logic [ADDR_W-1:0] SWAP_OFFSET  = 8'hfa;

   // Reset values
   localparam logic [DATA_W-1:0]     BOOST_RESET = 8'h00;
   localparam logic [PORT_COUNT-1:0] SWAP_RESET  = 5'h00;
   localparam logic [DATA_W-1:0]     READ_IDLE   = 8'h00;

   // Field positions in the downstream boost register
   localparam int DS1_BOOST_LSB = 0;
   localparam int DS2_BOOST_LSB = 2;
   localparam int DS3_BOOST_LSB = 4;
   localparam int DS4_BOOST_LSB = 6;

   // Field positions in the pin swap register
   localparam int SWAP_UP_BIT    = 0;
   localparam int SWAP_DS1_BIT   = 1;
   localparam int SWAP_DS4_BIT   = 4;
   localparam int SWAP_RSVD_LSB  = 5;
   localparam int SWAP_RSVD_W    = 3;
   localparam logic [SWAP_RSVD_W-1:0] SWAP_RSVD_READ = 3'h0;

   typedef enum logic [BOOST_W-1:0] {
      BOOST_NONE   = 2'b00,
      BOOST_LOW    = 2'b01,
      BOOST_MEDIUM = 2'b10,
      BOOST_HIGH   = 2'b11
   } boost_level_type;

   // One-hot drive levels toward the transceiver
   localparam logic [LEVEL_W-1:0] LEVEL_NONE   = 4'h1;
   localparam logic [LEVEL_W-1:0] LEVEL_LOW    = 4'h2;
   localparam logic [LEVEL_W-1:0] LEVEL_MEDIUM = 4'h4;
   localparam logic [LEVEL_W-1:0] LEVEL_HIGH   = 4'h8;

   function automatic logic [BOOST_W-1:0] boost_field(input logic [DATA_W-1:0] value,
                                                      input int lsb);
      boost_field = value[lsb +: BOOST_W];
   endfunction

   function automatic logic [LEVEL_W-1:0] boost_onehot(input logic [BOOST_W-1:0] sel);
      unique case (boost_level_type'(sel))
         BOOST_NONE:   boost_onehot = LEVEL_NONE;
         BOOST_LOW:    boost_onehot = LEVEL_LOW;
         BOOST_MEDIUM: boost_onehot = LEVEL_MEDIUM;
         BOOST_HIGH:   boost_onehot = LEVEL_HIGH;
      endcase
   endfunction

endpackage

// ---- rtl/pin_swap_lane.sv ----
// One port lane that routes the data functions to the two physical data pins
`timescale 1ns/1ps
module pin_swap_lane (
   input  wire logic clock_i,
   input  wire logic reset_i,
   input  wire logic swap_i,
   input  wire logic core_pos_out_i,
   input  wire logic core_pos_oe_n_i,
   input  wire logic core_neg_out_i,
   input  wire logic core_neg_oe_n_i,
   output logic      core_pos_in_o,
   output logic      core_neg_in_o,
   input  wire logic positive_data_pin_i,
   output logic      positive_data_pin_o,
   output logic      positive_data_pin_oe_n_o,
   input  wire logic negative_data_pin_i,
   output logic      negative_data_pin_o,
   output logic      negative_data_pin_oe_n_o
);

   // Pins idle undriven after reset so no port drives the cable before setup
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         positive_data_pin_o      <= 1'b0;
         positive_data_pin_oe_n_o <= 1'b1;
         negative_data_pin_o      <= 1'b0;
         negative_data_pin_oe_n_o <= 1'b1;
      end else if (swap_i) begin
         positive_data_pin_o      <= core_neg_out_i;
         positive_data_pin_oe_n_o <= core_neg_oe_n_i;
         negative_data_pin_o      <= core_pos_out_i;
         negative_data_pin_oe_n_o <= core_pos_oe_n_i;
      end else begin
         positive_data_pin_o      <= core_pos_out_i;
         positive_data_pin_oe_n_o <= core_pos_oe_n_i;
         negative_data_pin_o      <= core_neg_out_i;
         negative_data_pin_oe_n_o <= core_neg_oe_n_i;
      end
   end

   // Receive side follows the same swap so the core always sees true polarity
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         core_pos_in_o <= 1'b0;
         core_neg_in_o <= 1'b0;
      end else if (swap_i) begin
         core_pos_in_o <= negative_data_pin_i;
         core_neg_in_o <= positive_data_pin_i;
      end else begin
         core_pos_in_o <= positive_data_pin_i;
         core_neg_in_o <= negative_data_pin_i;
      end
   end

endmodule

// ---- test/port_phy_tuning_checker.sv ----
// Concurrent checks on the port tuning register bank ports
`timescale 1ns/1ps
module port_phy_tuning_checker (
   input wire logic       clock_i,
   input wire logic       reset_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_write_i,
   input wire logic       reg_read_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [1:0] ds1_drive_boost_o,
   input wire logic [1:0] ds2_drive_boost_o,
   input wire logic [1:0] ds3_drive_boost_o,
   input wire logic [1:0] ds4_drive_boost_o,
   input wire logic [3:0] ds1_drive_level_o,
   input wire logic [3:0] ds_boost_active_o,
   input wire logic [4:0] pin_swap_bits_o,
   input wire logic [4:0] core_pos_out_i,
   input wire logic [4:0] core_neg_out_i,
   input wire logic [4:0] positive_data_pin_o
);
   import port_phy_pkg::*;
   logic [4:0] tx_exp_reg;
   logic [7:0] boost_now;
   assign boost_now = {ds4_drive_boost_o, ds3_drive_boost_o, ds2_drive_boost_o, ds1_drive_boost_o};
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   // Lane uses the swap value standing before the edge
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) tx_exp_reg <= 5'h00;
      else tx_exp_reg <= (core_pos_out_i & ~pin_swap_bits_o) | (core_neg_out_i & pin_swap_bits_o);
   end
   a_boost_fields: assert property (reg_write_i && reg_addr_i == BOOST_OFFSET
      |=> boost_now == $past(reg_wdata_i)) else $error("boost fields differ from write");
   a_boost_unmapped: assert property (reg_write_i && reg_addr_i != BOOST_OFFSET
      |=> $stable(boost_now)) else $error("boost changed without its write");
   a_level_onehot: assert property (ds1_drive_level_o == 4'h1 << ds1_drive_boost_o)
      else $error("drive level does not match selector");
   a_active_flags: assert property (ds_boost_active_o == {|ds4_drive_boost_o,
      |ds3_drive_boost_o, |ds2_drive_boost_o, |ds1_drive_boost_o}) else $error("boost flag wrong");
   a_swap_write: assert property (reg_write_i && reg_addr_i == SWAP_OFFSET
      |=> pin_swap_bits_o == $past(reg_wdata_i[4:0])) else $error("swap bits differ from write");
   a_read_boost: assert property (reg_read_i && reg_addr_i == BOOST_OFFSET
      |=> reg_rdata_o == boost_now) else $error("boost readback wrong");
   a_read_swap: assert property (reg_read_i && reg_addr_i == SWAP_OFFSET
      |=> reg_rdata_o == {3'h0, pin_swap_bits_o}) else $error("swap readback wrong");
   a_rdata_idle: assert property (!reg_read_i |=> reg_rdata_o == 8'h00)
      else $error("read data not idle");
   a_lane_route: assert property (positive_data_pin_o == tx_exp_reg)
      else $error("positive pin routing wrong");
endmodule

bind port_phy_tuning_regs port_phy_tuning_checker chk (.*);

// ---- test/port_phy_tuning_regs_tb_top.sv ----
// Self-checking bench for the port tuning register bank
`timescale 1ns/1ps
module port_phy_tuning_regs_tb_top;
   import port_phy_pkg::*;
   logic       clock_i, reset_i, reg_write_i, reg_read_i;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, boost_model, swap_model;
   logic [1:0] ds1_drive_boost_o, ds2_drive_boost_o, ds3_drive_boost_o, ds4_drive_boost_o;
   logic [3:0] ds1_drive_level_o, ds2_drive_level_o, ds3_drive_level_o, ds4_drive_level_o;
   logic [3:0] ds_boost_active_o;
   logic [4:0] pin_swap_bits_o, core_pos_out_i, core_pos_oe_n_i, core_neg_out_i, core_neg_oe_n_i;
   logic [4:0] core_pos_in_o, core_neg_in_o, positive_data_pin_i, negative_data_pin_i;
   logic [4:0] positive_data_pin_o, positive_data_pin_oe_n_o;
   logic [4:0] negative_data_pin_o, negative_data_pin_oe_n_o;
   int         failures, total_checks;

   port_phy_tuning_regs dut (.*);

   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   function automatic logic [15:0] exp_levels(input logic [7:0] b);
      for (int n = 0; n < 4; n++)
         exp_levels[n*4 +: 4] = 4'h1 << b[n*2 +: 2];
   endfunction

   function automatic logic [4:0] route(input logic [4:0] a, b, s);
      return (a & ~s) | (b & s);
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Strobes are left standing so back-to-back calls assign each signal once per edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      reg_read_i  <= 1'b0;
      @(posedge clock_i);
      if (a == BOOST_OFFSET) boost_model = d;
      if (a == SWAP_OFFSET) swap_model = {3'h0, d[4:0]};
   endtask

   task automatic rd(input logic [7:0] a);
      logic [7:0] exp;
      exp = (a == BOOST_OFFSET) ? boost_model : (a == SWAP_OFFSET) ? swap_model : 8'h00;
      reg_addr_i  <= a;
      reg_write_i <= 1'b0;
      reg_read_i  <= 1'b1;
      @(posedge clock_i);
      reg_read_i <= 1'b0;
      // Look mid-cycle while the read data stand, away from the launching edge
      @(negedge clock_i);
      check({8'h00, reg_rdata_o}, {8'h00, exp});
      check({ds4_drive_boost_o, ds3_drive_boost_o, ds2_drive_boost_o, ds1_drive_boost_o,
             3'h0, pin_swap_bits_o}, {boost_model, swap_model});
      check({ds4_drive_level_o, ds3_drive_level_o, ds2_drive_level_o, ds1_drive_level_o},
            exp_levels(boost_model));
      check({12'h000, ds_boost_active_o}, {12'h000, |boost_model[7:6], |boost_model[5:4],
            |boost_model[3:2], |boost_model[1:0]});
      @(posedge clock_i);
   endtask

   task automatic lanes();
      logic [4:0] po, pe, no, ne, pi, ni, s;
      po = 5'($urandom);
      pe = 5'($urandom);
      no = 5'($urandom);
      ne = 5'($urandom);
      pi = 5'($urandom);
      ni = 5'($urandom);
      s  = swap_model[4:0];
      reg_write_i         <= 1'b0;
      reg_read_i          <= 1'b0;
      core_pos_out_i      <= po;
      core_pos_oe_n_i     <= pe;
      core_neg_out_i      <= no;
      core_neg_oe_n_i     <= ne;
      positive_data_pin_i <= pi;
      negative_data_pin_i <= ni;
      @(posedge clock_i);
      @(negedge clock_i);
      check({1'b0, positive_data_pin_o, negative_data_pin_o, core_pos_in_o},
            {1'b0, route(po, no, s), route(no, po, s), route(pi, ni, s)});
      check({1'b0, positive_data_pin_oe_n_o, negative_data_pin_oe_n_o, core_neg_in_o},
            {1'b0, route(pe, ne, s), route(ne, pe, s), route(ni, pi, s)});
      @(posedge clock_i);
   endtask

   initial begin
      #400000;
      failures++;
      $display("[FAIL] %0t run did not finish", $time);
      finish_test();
   end

   initial begin
      {reset_i, reg_write_i, reg_read_i, reg_addr_i, reg_wdata_i} = {1'b1, 18'h00000};
      {core_pos_out_i, core_neg_out_i, positive_data_pin_i, negative_data_pin_i} = 20'h00000;
      {core_pos_oe_n_i, core_neg_oe_n_i} = 10'h3ff;
      {boost_model, swap_model, failures, total_checks} = '0;
      void'($urandom(32'ha4aee123));
      repeat (12) @(posedge clock_i);
      reset_i <= 1'b0;
      @(posedge clock_i);
      rd(BOOST_OFFSET);
      rd(SWAP_OFFSET);
      lanes();
      $display("reset test done");
      for (int i = 0; i < 10; i++) begin
         wr(BOOST_OFFSET, i < 4 ? {4{2'(i)}} : i == 4 ? 8'he4 : i == 5 ? 8'h1b : 8'($urandom));
         rd(BOOST_OFFSET);
      end
      // Software leaves every selector at no boost once tuning is done
      wr(BOOST_OFFSET, 8'h00);
      rd(BOOST_OFFSET);
      $display("boost test done");
      for (int i = 0; i < 9; i++) begin
         wr(SWAP_OFFSET, i < 5 ? 8'h01 << i : i == 5 ? 8'hff : 8'($urandom));
         rd(SWAP_OFFSET);
         lanes();
      end
      $display("swap test done");
      wr(8'hf9, 8'hff);
      wr(8'hfb, 8'h5a);
      rd(8'hf9);
      rd(8'h00);
      $display("unmapped test done");
      finish_test();
   end
endmodule
